// ===== hdl/osa_core.sv
// Command logic for security-sector mode and the parameter-space read.
// Assumes the serial link pins are asynchronous and much slower than clk_i;
// the array engine outside reports its running cycle on busy_i (same clock).
//
// Overview of operation
// - Security sectors erase only by opcode 20h
// - Chip, 64K and 32K erases ignored here
// - Sectors sit at 0FF000h, 0FE000h, 0F0000h
// - One sector erase wipes a whole sector
// - Write-status sets lock bits once, never clears
// - Opcode 04h leaves security-sector mode
// - Enter command accepted in four-line mode too
// - Parameter bits driven on falling clock edges
// - Address advances by one per byte
// - Address wraps to zero past the top
// - Chip select high stops output, ends command
// - Parameter read rejected while array busy
// - Signature bytes 53h 46h 44h 50h
// - Minor revision 00h, major 01h
// - Header count 00h, address 07h reads FFh
// - Header ID 00h, revision 1.0, length 09h
// - Table pointer 000030h, address 0Fh FFh
// - Byte 30h bits 1:0 read 01b
// - Byte 31h reports erase opcode 20h
// - Secure-mode status shows locks and busy
`timescale 1ns/10ps
module osa_core (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic [3:0] dq_i,
	input wire logic busy_i,
	input wire logic [7:0] status_i,
	output logic so_o,
	output logic so_oe_o,
	output logic otp_mode_o,
	output logic four_line_o,
	output logic sector_lock_a_o,
	output logic sector_lock_b_o,
	output logic sector_lock_c_o,
	output logic erase_block_lock_o,
	output logic array_erase_o,
	output logic [7:0] erase_op_o,
	output logic [23:0] erase_addr_o,
	output logic otp_erase_o,
	output logic [1:0] otp_sector_o
);
	logic sclk_s1, sclk_s2, sclk_s3;
	logic cs_s1, cs_s2, cs_s3;
	logic [3:0] dq_s1, dq_s2;
	logic rise_w, fall_w, sel_w, cs_rise_w;
	osa_pkg::osa_state_t state_q;
	logic [5:0] cnt_q, step_w, cnt_inc_w;
	logic [7:0] sh_q, sh_d, opcode_q, data_q, out_sh_q, status_w;
	logic [23:0] addr_q;
	logic [2:0] obit_q;
	logic so_q;
	logic otp_q, quad_q, lock_a_q, lock_b_q, lock_c_q, eb_lock_q;
	logic erase_q, otp_erase_q;
	logic [7:0] erase_op_q;
	logic [23:0] erase_addr_q;
	logic [1:0] otp_sector_q;
	logic sec_hit_w, sec_locked_w;
	logic [1:0] sec_idx_w;

	// Parameter space: 256 bytes, unlisted locations read as fill
	function automatic logic [7:0] osa_param(input logic [7:0] a);
		unique case (a)
			8'h00: osa_param = osa_pkg::PRM_SIG0;
			8'h01: osa_param = osa_pkg::PRM_SIG1;
			8'h02: osa_param = osa_pkg::PRM_SIG2;
			8'h03: osa_param = osa_pkg::PRM_SIG3;
			8'h04: osa_param = osa_pkg::PRM_REV_MINOR;
			8'h05: osa_param = osa_pkg::PRM_REV_MAJOR;
			8'h06: osa_param = osa_pkg::PRM_HDR_COUNT;
			8'h07: osa_param = osa_pkg::PRM_FILL;
			8'h08: osa_param = osa_pkg::PRM_ID;
			8'h09: osa_param = osa_pkg::PRM_REV_MINOR;
			8'h0A: osa_param = osa_pkg::PRM_REV_MAJOR;
			8'h0B: osa_param = osa_pkg::PRM_TBL_LEN;
			8'h0C: osa_param = osa_pkg::PRM_TABLE_PTR[7:0];
			8'h0D: osa_param = osa_pkg::PRM_TABLE_PTR[15:8];
			8'h0E: osa_param = osa_pkg::PRM_TABLE_PTR[23:16];
			8'h30: osa_param = osa_pkg::PRM_ERASE_INFO;
			8'h31: osa_param = osa_pkg::OP_SECT_ERASE;
			8'h32: osa_param = osa_pkg::PRM_READ_INFO;
			8'h34: osa_param = osa_pkg::PRM_DENSITY[7:0];
			8'h35: osa_param = osa_pkg::PRM_DENSITY[15:8];
			8'h36: osa_param = osa_pkg::PRM_DENSITY[23:16];
			8'h37: osa_param = osa_pkg::PRM_DENSITY[31:24];
			default: osa_param = osa_pkg::PRM_FILL;
		endcase
	endfunction : osa_param

	// Two-flop synchronisers; a third flop on link clock and select feeds edge detection
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			sclk_s1 <= 1'b0;
			sclk_s2 <= 1'b0;
			sclk_s3 <= 1'b0;
			cs_s1 <= 1'b1;
			cs_s2 <= 1'b1;
			cs_s3 <= 1'b1;
			dq_s1 <= 4'h0;
			dq_s2 <= 4'h0;
		end else begin
			sclk_s1 <= sclk_i;
			sclk_s2 <= sclk_s1;
			sclk_s3 <= sclk_s2;
			cs_s1 <= cs_n_i;
			cs_s2 <= cs_s1;
			cs_s3 <= cs_s2;
			dq_s1 <= dq_i;
			dq_s2 <= dq_s1;
		end
	end

	// Edges and shifting; four-line mode takes opcodes four bits per edge
	assign rise_w = sclk_s2 & ~sclk_s3;
	assign fall_w = ~sclk_s2 & sclk_s3;
	assign sel_w = ~cs_s2;
	assign cs_rise_w = cs_s2 & ~cs_s3;
	assign step_w = (quad_q && state_q == osa_pkg::OSA_CMD) ? osa_pkg::STEP_FOUR : osa_pkg::STEP_ONE;
	assign cnt_inc_w = (cnt_q > osa_pkg::CNT_MAX - step_w) ? osa_pkg::CNT_MAX : cnt_q + step_w;
	assign sh_d = (step_w == osa_pkg::STEP_FOUR) ? {sh_q[3:0], dq_s2} : {sh_q[6:0], dq_s2[0]};

	// Status byte meaning depends on the mode
	always_comb begin
		status_w = {status_i[7:1], busy_i};
		if (otp_q) begin
			status_w = 8'h00;
			status_w[osa_pkg::ST_LOCK_A] = lock_a_q;
			status_w[osa_pkg::ST_EB_LOCK] = eb_lock_q;
			status_w[osa_pkg::ST_LOCK_B] = lock_b_q;
			status_w[osa_pkg::ST_LOCK_C] = lock_c_q;
			status_w[osa_pkg::ST_BUSY] = busy_i;
		end
	end

	// Instruction sequencer and serial output; chip select high resets it
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_q <= osa_pkg::OSA_CMD;
			cnt_q <= 6'h00;
			sh_q <= 8'h00;
			opcode_q <= 8'h00;
			data_q <= 8'h00;
			addr_q <= 24'h000000;
			out_sh_q <= 8'h00;
			obit_q <= 3'h0;
			so_q <= 1'b0;
		end else if (!sel_w) begin
			state_q <= osa_pkg::OSA_CMD;
			cnt_q <= 6'h00;
			obit_q <= 3'h0;
		end else if (rise_w) begin
			cnt_q <= cnt_inc_w;
			sh_q <= sh_d;
			unique case (state_q)
				osa_pkg::OSA_CMD: if (cnt_inc_w == osa_pkg::LEN_OPC) begin
					opcode_q <= sh_d;
					state_q <= osa_pkg::OSA_SKIP;
					if (!quad_q) begin
						unique case (sh_d)
							osa_pkg::OP_READ_PARAM: if (!busy_i) state_q <= osa_pkg::OSA_ADDR;
							osa_pkg::OP_SECT_ERASE, osa_pkg::OP_BLK_ERASE,
							osa_pkg::OP_HALF_ERASE: state_q <= osa_pkg::OSA_ADDR;
							osa_pkg::OP_WRITE_STATUS: state_q <= osa_pkg::OSA_DATAIN;
							osa_pkg::OP_READ_STATUS: begin
								state_q <= osa_pkg::OSA_SEND;
								out_sh_q <= status_w;
							end
							default: state_q <= osa_pkg::OSA_SKIP;
						endcase
					end
				end
				osa_pkg::OSA_ADDR: begin
					addr_q <= {addr_q[22:0], dq_s2[0]};
					if (cnt_inc_w == osa_pkg::LEN_ADDR) begin
						state_q <= (opcode_q == osa_pkg::OP_READ_PARAM) ? osa_pkg::OSA_DUMMY
							: osa_pkg::OSA_SKIP;
					end
				end
				osa_pkg::OSA_DUMMY: if (cnt_inc_w == osa_pkg::LEN_DUMMY) begin
					state_q <= osa_pkg::OSA_SEND;
					out_sh_q <= osa_param(addr_q[7:0]);
				end
				osa_pkg::OSA_DATAIN: if (cnt_inc_w == osa_pkg::LEN_WSR) begin
					data_q <= sh_d;
					state_q <= osa_pkg::OSA_SKIP;
				end
				osa_pkg::OSA_SEND, osa_pkg::OSA_SKIP: begin
				end
			endcase
		end else if (fall_w && state_q == osa_pkg::OSA_SEND) begin
			so_q <= out_sh_q[7];
			obit_q <= obit_q + 3'h1;
			if (obit_q == osa_pkg::LAST_BIT) begin
				if (opcode_q == osa_pkg::OP_READ_PARAM) begin
					// Only the low byte counts, so the top wraps to zero
					addr_q <= {addr_q[23:8], addr_q[7:0] + 8'h01};
					out_sh_q <= osa_param(addr_q[7:0] + 8'h01);
				end else begin
					out_sh_q <= status_w;
				end
			end else begin
				out_sh_q <= {out_sh_q[6:0], 1'b0};
			end
		end
	end

	assign so_o = so_q;
	assign so_oe_o = sel_w && state_q == osa_pkg::OSA_SEND;

	// Security sector decode of the erase address
	always_comb begin
		sec_hit_w = 1'b1;
		sec_idx_w = osa_pkg::SEC_A;
		unique case (addr_q[23:12])
			osa_pkg::SEC_A_BASE: sec_idx_w = osa_pkg::SEC_A;
			osa_pkg::SEC_B_BASE: sec_idx_w = osa_pkg::SEC_B;
			osa_pkg::SEC_C_BASE: sec_idx_w = osa_pkg::SEC_C;
			default: sec_hit_w = 1'b0;
		endcase
		sec_locked_w = (sec_idx_w == osa_pkg::SEC_A) ? lock_a_q
			: (sec_idx_w == osa_pkg::SEC_B) ? lock_b_q : lock_c_q;
	end

	// Commands act when chip select rises after an exact length
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			otp_q <= 1'b0;
			quad_q <= 1'b0;
			lock_a_q <= 1'b0;
			lock_b_q <= 1'b0;
			lock_c_q <= 1'b0;
			eb_lock_q <= 1'b0;
			erase_q <= 1'b0;
			otp_erase_q <= 1'b0;
			erase_op_q <= 8'h00;
			erase_addr_q <= 24'h000000;
			otp_sector_q <= 2'h0;
		end else begin
			erase_q <= 1'b0;
			otp_erase_q <= 1'b0;
			if (cs_rise_w && cnt_q == osa_pkg::LEN_OPC) begin
				if (opcode_q == osa_pkg::OP_WRITE_DISABLE) otp_q <= 1'b0;
				if (opcode_q == osa_pkg::OP_ENTER_OTP && !busy_i) otp_q <= 1'b1;
				if (opcode_q == osa_pkg::OP_FOUR_LINE) quad_q <= 1'b1;
				if (opcode_q == osa_pkg::OP_FOUR_LINE_EXIT) quad_q <= 1'b0;
				// Full-array erase only outside security-sector mode
				if ((opcode_q == osa_pkg::OP_CHIP_ERASE || opcode_q == osa_pkg::OP_CHIP_ERASE2)
					&& !otp_q && !busy_i) begin
					erase_q <= 1'b1;
					erase_op_q <= opcode_q;
				end
			end
			if (cs_rise_w && cnt_q == osa_pkg::LEN_WSR && otp_q && !busy_i
				&& opcode_q == osa_pkg::OP_WRITE_STATUS) begin
				// Bits only ever gain ones, the one-time behaviour
				lock_a_q <= lock_a_q | data_q[osa_pkg::ST_LOCK_A];
				lock_b_q <= lock_b_q | data_q[osa_pkg::ST_LOCK_B];
				lock_c_q <= lock_c_q | data_q[osa_pkg::ST_LOCK_C];
				eb_lock_q <= eb_lock_q | data_q[osa_pkg::ST_EB_LOCK];
			end
			if (cs_rise_w && cnt_q == osa_pkg::LEN_ADDR && !busy_i) begin
				erase_addr_q <= addr_q;
				if (otp_q) begin
					// A single request clears the whole 4 KB sector (address bits 23:12 select it)
					if (opcode_q == osa_pkg::OP_SECT_ERASE && sec_hit_w && !sec_locked_w) begin
						otp_erase_q <= 1'b1;
						otp_sector_q <= sec_idx_w;
					end
				end else if (opcode_q == osa_pkg::OP_SECT_ERASE || opcode_q == osa_pkg::OP_BLK_ERASE
					|| opcode_q == osa_pkg::OP_HALF_ERASE) begin
					erase_q <= 1'b1;
					erase_op_q <= opcode_q;
				end
			end
		end
	end

	assign otp_mode_o = otp_q;
	assign four_line_o = quad_q;
	assign sector_lock_a_o = lock_a_q;
	assign sector_lock_b_o = lock_b_q;
	assign sector_lock_c_o = lock_c_q;
	assign erase_block_lock_o = eb_lock_q;
	assign array_erase_o = erase_q;
	assign erase_op_o = erase_op_q;
	assign erase_addr_o = erase_addr_q;
	assign otp_erase_o = otp_erase_q;
	assign otp_sector_o = otp_sector_q;

	// Checks
	otp_no_array_a: assert property (@(posedge clk_i) disable iff (reset_i)
		erase_q |-> !$past(otp_q)) else $error("array erase in secure mode");
	otp_sect_op_a: assert property (@(posedge clk_i) disable iff (reset_i)
		otp_erase_q |-> $past(opcode_q) == osa_pkg::OP_SECT_ERASE) else $error("bad sector erase");
	sect_map_a: assert property (@(posedge clk_i) disable iff (reset_i)
		otp_erase_q && otp_sector_q == osa_pkg::SEC_A |-> erase_addr_q[23:12] == osa_pkg::SEC_A_BASE)
		else $error("sector map wrong");
	lock_sticky_a: assert property (@(posedge clk_i) disable iff (reset_i)
		!$fell(lock_a_q) && !$fell(lock_b_q) && !$fell(lock_c_q) && !$fell(eb_lock_q))
		else $error("lock bit cleared");
	write_disable_cmd_exit_a: assert property (@(posedge clk_i) disable iff (reset_i)
		cs_rise_w && cnt_q == osa_pkg::LEN_OPC && opcode_q == osa_pkg::OP_WRITE_DISABLE |=> !otp_q)
		else $error("mode not left");
	out_on_fall_a: assert property (@(posedge clk_i) disable iff (reset_i)
		$changed(so_q) |-> $past(fall_w)) else $error("output moved off falling edge");
	addr_step_a: assert property (@(posedge clk_i) disable iff (reset_i)
		sel_w && fall_w && state_q == osa_pkg::OSA_SEND && obit_q == osa_pkg::LAST_BIT
		&& opcode_q == osa_pkg::OP_READ_PARAM |=> addr_q[7:0] == $past(addr_q[7:0]) + 8'h01)
		else $error("address not advanced");
	cs_stop_a: assert property (@(posedge clk_i) disable iff (reset_i)
		cs_s2 |=> !so_oe_o) else $error("driving while deselected");
	busy_reject_a: assert property (@(posedge clk_i) disable iff (reset_i)
		sel_w && state_q == osa_pkg::OSA_CMD && rise_w && cnt_inc_w == osa_pkg::LEN_OPC && busy_i
		&& !quad_q && sh_d == osa_pkg::OP_READ_PARAM |=> state_q == osa_pkg::OSA_SKIP)
		else $error("read accepted while busy");
	sig_first_a: assert property (@(posedge clk_i) disable iff (reset_i)
		$rose(state_q == osa_pkg::OSA_SEND) && opcode_q == osa_pkg::OP_READ_PARAM
		&& addr_q[7:0] == 8'h00 |-> out_sh_q == osa_pkg::PRM_SIG0) else $error("bad signature");
	param_read_c: cover property (@(posedge clk_i) disable iff (reset_i)
		state_q == osa_pkg::OSA_SEND && opcode_q == osa_pkg::OP_READ_PARAM);
	otp_erase_c: cover property (@(posedge clk_i) disable iff (reset_i) otp_erase_q);
	lock_set_c: cover property (@(posedge clk_i) disable iff (reset_i) $rose(lock_a_q));
endmodule : osa_core

// ===== hdl/osa_pkg.sv
// Constants for the security-sector and parameter-read command logic.
// Assumes one serial link: opcodes arrive most significant bit first.
package osa_pkg;
	// Opcodes
	localparam logic [7:0] OP_SECT_ERASE = 8'h20;
	localparam logic [7:0] OP_HALF_ERASE = 8'h52;
	localparam logic [7:0] OP_BLK_ERASE = 8'hD8;
	localparam logic [7:0] OP_CHIP_ERASE = 8'hC7;
	localparam logic [7:0] OP_CHIP_ERASE2 = 8'h60;
	localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
	localparam logic [7:0] OP_READ_STATUS = 8'h05;
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OP_ENTER_OTP = 8'h3A;
	localparam logic [7:0] OP_FOUR_LINE = 8'h38;
	localparam logic [7:0] OP_FOUR_LINE_EXIT = 8'hFF;
	localparam logic [7:0] OP_READ_PARAM = 8'h5A;
	// Bit counts at the end of each phase
	localparam logic [5:0] LEN_OPC = 6'h08;
	localparam logic [5:0] LEN_WSR = 6'h10;
	localparam logic [5:0] LEN_ADDR = 6'h20;
	localparam logic [5:0] LEN_DUMMY = 6'h28;
	localparam logic [5:0] CNT_MAX = 6'h3F;
	localparam logic [5:0] STEP_ONE = 6'h01;
	localparam logic [5:0] STEP_FOUR = 6'h04;
	localparam logic [2:0] LAST_BIT = 3'h7;
	// Security sector placement: address bits 23:12 and sector index
	localparam logic [11:0] SEC_A_BASE = 12'h0FF;
	localparam logic [11:0] SEC_B_BASE = 12'h0FE;
	localparam logic [11:0] SEC_C_BASE = 12'h0F0;
	localparam logic [1:0] SEC_A = 2'h0;
	localparam logic [1:0] SEC_B = 2'h1;
	localparam logic [1:0] SEC_C = 2'h2;
	// Status bit positions while in security-sector mode
	localparam int ST_LOCK_A = 7;
	localparam int ST_EB_LOCK = 3;
	localparam int ST_LOCK_B = 2;
	localparam int ST_LOCK_C = 1;
	localparam int ST_BUSY = 0;
	// Parameter space contents
	localparam logic [7:0] PRM_FILL = 8'hFF;
	localparam logic [7:0] PRM_LAST = 8'hFF;
	localparam logic [7:0] PRM_SIG0 = 8'h53;
	localparam logic [7:0] PRM_SIG1 = 8'h46;
	localparam logic [7:0] PRM_SIG2 = 8'h44;
	localparam logic [7:0] PRM_SIG3 = 8'h50;
	localparam logic [7:0] PRM_REV_MINOR = 8'h00;
	localparam logic [7:0] PRM_REV_MAJOR = 8'h01;
	localparam logic [7:0] PRM_HDR_COUNT = 8'h00;
	localparam logic [7:0] PRM_ID = 8'h00;
	localparam logic [7:0] PRM_TBL_LEN = 8'h09;
	localparam logic [23:0] PRM_TABLE_PTR = 24'h000030;
	localparam logic [7:0] PRM_ERASE_INFO = 8'hED;
	localparam logic [7:0] PRM_READ_INFO = 8'hF1;
	localparam logic [31:0] PRM_DENSITY = 32'h007FFFFF;
	typedef enum logic [2:0] {
		OSA_CMD = 3'b000,
		OSA_ADDR = 3'b001,
		OSA_DUMMY = 3'b010,
		OSA_SEND = 3'b011,
		OSA_DATAIN = 3'b100,
		OSA_SKIP = 3'b101
	} osa_state_t;
endpackage : osa_pkg

// ===== tb/osa_host_model.sv
// Host model: drives link clock, chip select and the four data lines.
// Assumes clk_i is the system clock; link period is eight of its cycles.
`timescale 1ns/10ps
module osa_host_model (
	input wire logic clk_i,
	input wire logic so_i,
	output logic sclk_o,
	output logic cs_n_o,
	output logic [3:0] dq_o
);
	// Link clock stands low between frames
	initial begin
		sclk_o = 1'h0;
		cs_n_o = 1'h1;
		dq_o = 4'h5;
	end
	task automatic half();
		repeat (4) @(negedge clk_i);
	endtask : half
	// One rise then one fall of the link clock
	task automatic pulse();
		half();
		sclk_o = 1'h1;
		half();
		sclk_o = 1'h0;
	endtask : pulse
	task automatic select();
		@(negedge clk_i);
		cs_n_o = 1'h0;
		half();
	endtask : select
	// Released lines flip so a stale level never looks valid
	task automatic deselect();
		half();
		cs_n_o = 1'h1;
		dq_o = ~dq_o;
		repeat (8) @(negedge clk_i);
	endtask : deselect
	// Bit set while clock low, taken at the rise, MSB first
	task automatic send_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			dq_o[0] = b[i];
			pulse();
		end
	endtask : send_byte
	// Four-line opcode: high nibble first
	task automatic send_quad(input logic [7:0] b);
		dq_o = b[7:4];
		pulse();
		dq_o = b[3:0];
		pulse();
	endtask : send_quad
	// Sampled at the rise, half a period after the device's fall
	task automatic recv_byte(output logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			dq_o = ~dq_o;
			half();
			sclk_o = 1'h1;
			b[i] = so_i;
			half();
			sclk_o = 1'h0;
		end
	endtask : recv_byte
endmodule : osa_host_model

// ===== tb/osa_core_tb_top.sv
// Self-checking bench for the security-sector and parameter-read logic.
// Assumes the host model drives the link; the bench owns busy and status.
`timescale 1ns/10ps
module osa_core_tb_top;
	logic clk_i = 1'h0;
	logic reset_i = 1'h1;
	logic busy_i = 1'h0;
	logic [7:0] status_i = 8'h00;
	logic sclk, cs_n, so_o, so_oe_o, otp_mode_o, four_line_o, oe_seen, so_line;
	logic lk_a, lk_b, lk_c, lk_eb, arr_er, otp_er;
	logic [3:0] dq;
	logic [7:0] erase_op, n_otp = 8'h00, n_arr = 8'h00;
	logic [23:0] erase_addr;
	logic [1:0] sec, last_sec;
	int failures = 0;
	int checks = 0;
	logic [7:0] hdr [16] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h00, 8'hFF,
		8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hFF};
	always #25 clk_i = ~clk_i;
	// Undriven output shows the inverse, so a read of a released line fails
	assign so_line = so_oe_o ? so_o : ~so_o;
	osa_host_model host (.clk_i(clk_i), .so_i(so_line), .sclk_o(sclk), .cs_n_o(cs_n), .dq_o(dq));
	osa_core DUT (.clk_i(clk_i), .reset_i(reset_i), .sclk_i(sclk), .cs_n_i(cs_n), .dq_i(dq),
		.busy_i(busy_i), .status_i(status_i), .so_o(so_o), .so_oe_o(so_oe_o),
		.otp_mode_o(otp_mode_o), .four_line_o(four_line_o), .sector_lock_a_o(lk_a),
		.sector_lock_b_o(lk_b), .sector_lock_c_o(lk_c), .erase_block_lock_o(lk_eb),
		.array_erase_o(arr_er), .erase_op_o(erase_op), .erase_addr_o(erase_addr),
		.otp_erase_o(otp_er), .otp_sector_o(sec));
	// Pulses last one cycle; counted mid-cycle where they are settled
	always @(negedge clk_i) begin
		if (otp_er === 1'h1) begin
			n_otp = n_otp + 8'h01;
			last_sec = sec;
		end
		if (arr_er === 1'h1)
			n_arr = n_arr + 8'h01;
		if (so_oe_o === 1'h1)
			oe_seen = 1'h1;
	end
	task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic complete_run();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : complete_run
	task automatic cmd1(input logic [7:0] op);
		host.select();
		host.send_byte(op);
		host.deselect();
	endtask : cmd1
	task automatic cmd2(input logic [7:0] op, input logic [7:0] d);
		host.select();
		host.send_byte(op);
		host.send_byte(d);
		host.deselect();
	endtask : cmd2
	task automatic cmd_addr(input logic [7:0] op, input logic [23:0] a);
		host.select();
		host.send_byte(op);
		host.send_byte(a[23:16]);
		host.send_byte(a[15:8]);
		host.send_byte(a[7:0]);
		host.deselect();
	endtask : cmd_addr
	task automatic quad(input logic [7:0] op);
		host.select();
		host.send_quad(op);
		host.deselect();
	endtask : quad
	// Opcode, three address bytes and a dummy; chip stays selected
	task automatic open_param(input logic [7:0] a);
		host.select();
		host.send_byte(8'h5A);
		host.send_byte(8'h00);
		host.send_byte(8'h00);
		host.send_byte(a);
		host.send_byte(8'h00);
	endtask : open_param
	task automatic t_reset();
		check("modes", {otp_mode_o, four_line_o, so_oe_o}, 8'h00);
		check("locks", {lk_a, lk_b, lk_c, lk_eb}, 8'h00);
	endtask : t_reset
	task automatic t_header();
		logic [7:0] b;
		open_param(8'h00);
		for (int i = 0; i < 16; i++) begin
			host.recv_byte(b);
			check("header byte", b, hdr[i]);
			check("enable", so_oe_o, 8'h01);
		end
		host.deselect();
		check("enable after deselect", so_oe_o, 8'h00);
	endtask : t_header
	// Start at FEh near the top: crosses the wrap into the signature
	task automatic t_wrap();
		logic [7:0] b;
		logic [7:0] exp [4] = '{8'hFF, 8'hFF, 8'h53, 8'h46};
		open_param(8'hFE);
		for (int i = 0; i < 4; i++) begin
			host.recv_byte(b);
			check("wrap byte", b, exp[i]);
		end
		host.deselect();
	endtask : t_wrap
	task automatic t_table();
		logic [7:0] b;
		open_param(8'h30);
		host.recv_byte(b);
		check("erase sizes", {6'h00, b[1:0]}, 8'h01);
		host.recv_byte(b);
		check("erase opcode", b, 8'h20);
		host.deselect();
	endtask : t_table
	task automatic t_busy();
		logic [7:0] b;
		@(negedge clk_i);
		busy_i = 1'h1;
		oe_seen = 1'h0;
		open_param(8'h00);
		host.recv_byte(b);
		host.deselect();
		check("output while busy", oe_seen, 8'h00);
		busy_i = 1'h0;
	endtask : t_busy
	// Mode entered first, each sector erased with a single command
	task automatic t_otp_erase();
		logic [23:0] base [3] = '{24'h0FF000, 24'h0FE000, 24'h0F0000};
		cmd1(8'h3A);
		check("secure mode", otp_mode_o, 8'h01);
		cmd1(8'hC7);
		cmd1(8'h60);
		cmd_addr(8'hD8, 24'h0FF000);
		cmd_addr(8'h52, 24'h0FE000);
		check("array erases", n_arr, 8'h00);
		check("sector erases", n_otp, 8'h00);
		for (int i = 0; i < 3; i++) begin
			cmd_addr(8'h20, base[i] + 24'h000100);
			check("sector erases", n_otp, 8'(i + 1));
			check("sector", {6'h00, last_sec}, 8'(i));
		end
		check("array erases", n_arr, 8'h00);
	endtask : t_otp_erase
	task automatic t_locks();
		logic [7:0] b;
		cmd2(8'h01, 8'h80);
		check("locks", {lk_a, lk_b, lk_c, lk_eb}, 8'h08);
		cmd2(8'h01, 8'h0E);
		check("locks", {lk_a, lk_b, lk_c, lk_eb}, 8'h0F);
		cmd2(8'h01, 8'h00);
		check("locks", {lk_a, lk_b, lk_c, lk_eb}, 8'h0F);
		@(negedge clk_i);
		busy_i = 1'h1;
		host.select();
		host.send_byte(8'h05);
		host.recv_byte(b);
		host.deselect();
		busy_i = 1'h0;
		check("secure status", b, 8'h8F);
		cmd_addr(8'h20, 24'h0FF000);
		check("locked sector erase", n_otp, 8'h03);
		cmd1(8'h04);
		check("secure mode", otp_mode_o, 8'h00);
	endtask : t_locks
	task automatic t_quad();
		cmd1(8'h38);
		check("four-line", four_line_o, 8'h01);
		quad(8'h3A);
		check("secure mode", otp_mode_o, 8'h01);
		quad(8'h04);
		check("secure mode", otp_mode_o, 8'h00);
		quad(8'hFF);
		check("four-line", four_line_o, 8'h00);
	endtask : t_quad
	// Outside secure mode erases reach the array and status is external
	task automatic t_array();
		logic [7:0] b;
		cmd_addr(8'hD8, 24'h0FF000);
		check("array erases", n_arr, 8'h01);
		check("erase opcode out", erase_op, 8'hD8);
		check("erase address", erase_addr, 24'h0FF000);
		cmd1(8'hC7);
		check("array erases", n_arr, 8'h02);
		check("erase opcode out", erase_op, 8'hC7);
		check("sector erases", n_otp, 8'h03);
		@(negedge clk_i);
		status_i = 8'hA4;
		host.select();
		host.send_byte(8'h05);
		host.recv_byte(b);
		host.deselect();
		check("normal status", b, 8'hA4);
	endtask : t_array
	// Watchdog cuts a hang short
	initial begin
		repeat (100000) @(posedge clk_i);
		failures++;
		complete_run();
	end
	initial begin
		repeat (20) @(negedge clk_i);
		reset_i = 1'h0;
		repeat (4) @(negedge clk_i);
		t_reset();
		t_header();
		t_wrap();
		t_table();
		t_busy();
		t_otp_erase();
		t_locks();
		t_quad();
		t_array();
		complete_run();
	end
endmodule : osa_core_tb_top
